// ---- hw/bps_strobes.sv ----
// Bus phase strobe sequencer for a multiplexed address/data bus
`timescale 1ns/1ps
// Function
// - Address latch strobe is high while the bus carries a valid address.
// - Read drive enable rises only after the device has let go of the bus.
// - Read drive enable stays low in writes and when the bus is idle.
// - In a read the diagnostic flag is high for fetches, low for data.
// - Configuration pins are inputs in reset and normal after release.
// - The diagnostic pin shows read qualifiers while the bus carries address, zero in writes.
// - In a read address phase the cached flag is high on a cache miss.
module bps_strobes #(
    parameter int unsigned AD_WIDTH  = bps_pkg::AD_WIDTH,
    parameter int unsigned CFG_WIDTH = bps_pkg::CFG_WIDTH
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Core request
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire logic                 req_write,
    input  wire logic                 req_fetch,
    input  wire logic                 req_miss,
    input  wire logic [AD_WIDTH-1:0]  req_addr,
    input  wire logic [AD_WIDTH-1:0]  req_wdata,
    // Core completion
    input  wire logic                 xfer_done,
    output logic      [AD_WIDTH-1:0]  rdata,
    output logic                      rdata_valid,
    // Multiplexed bus
    input  wire logic [AD_WIDTH-1:0]  ad_in,
    output logic      [AD_WIDTH-1:0]  ad_out,
    output logic                      ad_oe_n,
    // Phase strobes
    output logic                      addr_latch_strobe,
    output logic                      read_data_drive_enable,
    // Diagnostic pin, cached flag then fetch flag
    output logic      [1:0]           diag_out,
    // Reset configuration
    input  wire logic [CFG_WIDTH-1:0] cfg_pin_in,
    output logic      [CFG_WIDTH-1:0] cfg_value,
    output logic                      cfg_pins_normal
);
    bps_pkg::bps_phase_type state_d;
    bps_pkg::bps_phase_type state_q;
    logic                   write_d;
    logic                   write_q;
    logic [AD_WIDTH-1:0]    ad_d;
    logic [AD_WIDTH-1:0]    ad_q;
    logic                   oe_n_d;
    logic                   oe_n_q;
    logic                   ale_d;
    logic                   ale_q;
    logic                   rde_d;
    logic                   rde_q;
    logic [1:0]             diag_d;
    logic [1:0]             diag_q;
    logic [AD_WIDTH-1:0]    rdata_d;
    logic [AD_WIDTH-1:0]    rdata_q;
    logic                   rvalid_d;
    logic                   rvalid_q;
    logic [AD_WIDTH-1:0]    wdata_d;
    logic [AD_WIDTH-1:0]    wdata_q;

    // ------------------------------------------------------------
    // Reset configuration capture
    // ------------------------------------------------------------
    bps_cfg_capture #(
        .WIDTH           (CFG_WIDTH)
    ) u_cfg (
        .clk             (clk),
        .rst             (rst),
        .cfg_pin_in      (cfg_pin_in),
        .cfg_value       (cfg_value),
        .cfg_pins_normal (cfg_pins_normal)
    );

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        write_d  = write_q;
        ad_d     = ad_q;
        oe_n_d   = oe_n_q;
        ale_d    = 1'b0;
        rde_d    = 1'b0;
        diag_d   = diag_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        wdata_d  = wdata_q;
        case (state_q)
            bps_pkg::BPS_IDLE: begin
                oe_n_d = 1'b1;
                if (req_valid) begin
                    state_d = bps_pkg::BPS_ADDR;
                    write_d = req_write;
                    wdata_d = req_wdata;
                    ad_d    = req_addr;
                    oe_n_d  = 1'b0;
                    ale_d   = 1'b1;
                    // Qualifiers only meaningful in reads
                    diag_d  = req_write ? 2'h0
                                        : {req_miss, req_fetch};
                end
            end
            bps_pkg::BPS_ADDR: begin
                // Strobe drops before data or release
                ale_d = 1'b0;
                if (write_q) begin
                    state_d = bps_pkg::BPS_WDATA;
                    ad_d    = wdata_q;
                end else begin
                    state_d = bps_pkg::BPS_TURN;
                    oe_n_d  = 1'b1;
                end
            end
            bps_pkg::BPS_TURN: begin
                // Enable only after our drivers are off
                state_d = bps_pkg::BPS_RDATA;
                rde_d   = 1'b1;
            end
            bps_pkg::BPS_RDATA: begin
                rde_d = 1'b1;
                if (xfer_done) begin
                    state_d  = bps_pkg::BPS_IDLE;
                    rde_d    = 1'b0;
                    rdata_d  = ad_in;
                    rvalid_d = 1'b1;
                end
            end
            bps_pkg::BPS_WDATA: begin
                if (xfer_done) begin
                    state_d = bps_pkg::BPS_IDLE;
                    oe_n_d  = 1'b1;
                end
            end
            default: begin
                state_d = bps_pkg::BPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= bps_pkg::BPS_IDLE;
            write_q  <= 1'b0;
            ad_q     <= '0;
            oe_n_q   <= 1'b1;
            ale_q    <= 1'b0;
            rde_q    <= 1'b0;
            diag_q   <= 2'h0;
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            wdata_q  <= '0;
        end else begin
            state_q  <= state_d;
            write_q  <= write_d;
            ad_q     <= ad_d;
            oe_n_q   <= oe_n_d;
            ale_q    <= ale_d;
            rde_q    <= rde_d;
            diag_q   <= diag_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            wdata_q  <= wdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready              = (state_q == bps_pkg::BPS_IDLE);
    assign ad_out                 = ad_q;
    assign ad_oe_n                = oe_n_q;
    assign addr_latch_strobe      = ale_q;
    assign read_data_drive_enable = rde_q;
    assign diag_out               = diag_q;
    assign rdata                  = rdata_q;
    assign rdata_valid            = rvalid_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_read_start;
        req_valid && req_ready && !req_write;
    endsequence

    sequence s_read_enable;
        !read_data_drive_enable ##1 ad_oe_n && !read_data_drive_enable
        ##1 read_data_drive_enable;
    endsequence

    chk_ale_on_start: assert property (
        @(posedge clk) disable iff (rst)
        req_valid && req_ready |=> addr_latch_strobe && !ad_oe_n
        && ad_out == $past(req_addr))
        else $error("Address strobe missing with address");

    chk_rde_no_clash: assert property (
        @(posedge clk) disable iff (rst)
        read_data_drive_enable |-> ad_oe_n)
        else $error("Drive enable while device drives bus");

    chk_read_sequence: assert property (
        @(posedge clk) disable iff (rst)
        s_read_start |=> s_read_enable)
        else $error("Read turnaround sequence wrong");

    chk_rde_write_low: assert property (
        @(posedge clk) disable iff (rst)
        (write_q || state_q == bps_pkg::BPS_IDLE)
        |-> !read_data_drive_enable)
        else $error("Drive enable in write or idle");

    chk_fetch_flag: assert property (
        @(posedge clk) disable iff (rst)
        s_read_start |=> diag_out[0] == $past(req_fetch))
        else $error("Fetch flag wrong in read");

    chk_miss_flag: assert property (
        @(posedge clk) disable iff (rst)
        s_read_start |=> diag_out[1] == $past(req_miss)
        && addr_latch_strobe)
        else $error("Cached flag wrong in read address phase");

    chk_diag_stable: assert property (
        @(posedge clk) disable iff (rst)
        addr_latch_strobe |=> $stable(diag_out))
        else $error("Qualifiers moved after address phase");

    chk_ale_before_data: assert property (
        @(posedge clk) disable iff (rst)
        addr_latch_strobe |=> !addr_latch_strobe
        && (write_q ? ad_out == wdata_q : ad_oe_n))
        else $error("Address strobe overlaps data or release");
endmodule // bps_strobes

// ---- shared/bps_pkg.sv ----
// Package of constants and types for the bus phase strobe block
package bps_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned AD_WIDTH    = 32;
    localparam int unsigned CFG_WIDTH   = 4;
    // ------------------------------------------------------------
    // Timing in cycles
    // ------------------------------------------------------------
    localparam int unsigned ADDR_CYCLES = 1;
    localparam int unsigned TURN_CYCLES = 1;
    localparam logic [7:0]  WAIT_MAX_RST = 8'h00;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  CFG_RST     = 4'h0;
    // ------------------------------------------------------------
    // Bus phase states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BPS_IDLE,
        BPS_ADDR,
        BPS_TURN,
        BPS_RDATA,
        BPS_WDATA
    } bps_phase_type;
endpackage

// ---- hw/bps_cfg_capture.sv ----
// Reset configuration capture for the bus phase strobe block
`timescale 1ns/1ps
module bps_cfg_capture #(
    parameter int unsigned WIDTH = bps_pkg::CFG_WIDTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Configuration pins
    input  wire logic [WIDTH-1:0] cfg_pin_in,
    // Captured value
    output logic      [WIDTH-1:0] cfg_value,
    output logic                  cfg_pins_normal
);
    logic [WIDTH-1:0] cfg_d;
    logic [WIDTH-1:0] cfg_q;
    logic             norm_d;
    logic             norm_q;

    // ------------------------------------------------------------
    // Sample pins while reset is held
    // ------------------------------------------------------------
    always_comb begin
        cfg_d  = cfg_q;
        norm_d = 1'b1;
        if (rst) begin
            cfg_d  = cfg_pin_in;
            norm_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        cfg_q  <= cfg_d;
        norm_q <= norm_d;
    end

    assign cfg_value       = cfg_q;
    assign cfg_pins_normal = norm_q;

    chk_cfg_hold_after: assert property (
        @(posedge clk) disable iff (rst)
        norm_q |-> cfg_q == $past(cfg_q))
        else $error("Configuration changed after reset release");
endmodule // bps_cfg_capture

// ---- tb/bps_mem_model.sv ----
// Memory system and address latch model on the far side of the bus
`timescale 1ns/1ps
module bps_mem_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Device side of the bus
    input  wire logic        ale,
    input  wire logic        rde,
    input  wire logic        ad_oe_n,
    input  wire logic [31:0] ad_out,
    output logic      [31:0] ad_in,
    output logic             xfer_done,
    // Bench control and observation
    input  wire logic [7:0]  wait_cycles,
    output logic      [31:0] addr_q,
    output logic      [31:0] wdata_q
);
    logic [31:0] last_q;
    logic        active_q;
    logic [7:0]  cnt_q;
    logic        data_phase;
    // Qualifier pin is never looked at here
    assign data_phase = active_q && !ale && (rde || !ad_oe_n);
    // Released bus with rde low shows the inverse of the last level driven on it
    always_comb begin
        if (!ad_oe_n) begin
            ad_in = ad_out;
        end else if (rde) begin
            ad_in = addr_q ^ 32'h0f0f_0f0f;
        end else begin
            ad_in = ~last_q;
        end
    end
    always_ff @(posedge clk) begin
        xfer_done <= 1'b0;
        if (!ad_oe_n || rde) begin
            last_q <= ad_in;
        end
        if (rst) begin
            last_q <= 32'h0;
            active_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (ale) begin
            addr_q <= ad_in;
            active_q <= 1'b1;
            cnt_q <= 8'h00;
        end else if (data_phase) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == wait_cycles) begin
                xfer_done <= 1'b1;
                active_q <= 1'b0;
                if (!ad_oe_n) wdata_q <= ad_out;
            end
        end
    end
endmodule // bps_mem_model

// ---- tb/test_bps_strobes.sv ----
// Testbench for the bus phase strobe block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_bps_strobes;
    logic        clk, rst, req_valid, req_write, req_fetch, req_miss;
    logic [31:0] req_addr, req_wdata, ad_in, ad_out, rdata, maddr, mwdata;
    logic        xfer_done, rdata_valid, ad_oe_n, req_ready, ale, rde, normal;
    logic [1:0]  diag_out;
    logic [3:0]  cfg_pin_in, cfg_value;
    logic [7:0]  wait_cycles;
    int          failures = 0;
    int          cmp_count = 0;

    bps_strobes uut (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_fetch(req_fetch),
        .req_miss(req_miss), .req_addr(req_addr), .req_wdata(req_wdata),
        .xfer_done(xfer_done), .rdata(rdata), .rdata_valid(rdata_valid),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .addr_latch_strobe(ale), .read_data_drive_enable(rde),
        .diag_out(diag_out), .cfg_pin_in(cfg_pin_in), .cfg_value(cfg_value),
        .cfg_pins_normal(normal));
    bps_mem_model mem (.clk(clk), .rst(rst), .ale(ale), .rde(rde),
        .ad_oe_n(ad_oe_n), .ad_out(ad_out), .ad_in(ad_in),
        .xfer_done(xfer_done), .wait_cycles(wait_cycles), .addr_q(maddr),
        .wdata_q(mwdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One transfer, judged cycle by cycle
    task automatic run_xfer(input logic w, f, m, input logic [31:0] a, d,
                            input logic [7:0] ws);
        int n;
        @(posedge clk);
        wait_cycles <= ws;
        req_valid <= 1'b1;
        req_write <= w;
        req_fetch <= f;
        req_miss <= m;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        `CHK(ale, 1'b1)
        `CHK(ad_out, a)
        `CHK(ad_oe_n, 1'b0)
        `CHK(req_ready, 1'b0)
        `CHK(diag_out, w ? 2'h0 : {m, f})
        @(posedge clk);
        #1;
        `CHK(ad_oe_n, w ? 1'b0 : 1'b1)
        if (w) `CHK(ad_out, d)
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            `CHK(ale, 1'b0)
            `CHK(rde & w, 1'b0)
            `CHK(rde & ~ad_oe_n, 1'b0)
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 40) begin
            failures++;
            results();
        end
        if (!w) begin
            `CHK(rdata_valid, 1'b1)
            `CHK(rdata, a ^ 32'h0f0f_0f0f)
            `CHK(rde, 1'b0)
        end
    endtask

    task automatic test_reset_cfg;
        repeat (9) @(posedge clk);
        cfg_pin_in <= 4'hc;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(cfg_value, 4'hc)
        `CHK(normal, 1'b0)
        @(posedge clk);
        cfg_pin_in <= 4'h6;
        repeat (2) @(posedge clk);
        #1;
        `CHK(cfg_value, 4'hc)
        `CHK(normal, 1'b1)
        $display("test_reset_cfg done");
    endtask

    task automatic test_reads;
        for (int i = 0; i < 4; i++) begin
            run_xfer(1'b0, i[0], i[1], 32'h1000_0000 + i, 32'h0, 8'(i * 2));
        end
        $display("test_reads done");
    endtask

    task automatic test_writes;
        run_xfer(1'b1, 1'b1, 1'b1, 32'h8000_0040, 32'hdead_beef, 8'h00);
        `CHK(maddr, 32'h8000_0040)
        `CHK(mwdata, 32'hdead_beef)
        run_xfer(1'b0, 1'b1, 1'b0, 32'h0000_0ffc, 32'h0, 8'h00);
        run_xfer(1'b1, 1'b0, 1'b1, 32'h7fff_fff0, 32'h1234_5678, 8'h04);
        `CHK(maddr, 32'h7fff_fff0)
        `CHK(mwdata, 32'h1234_5678)
        $display("test_writes done");
    endtask

    task automatic test_idle;
        repeat (8) begin
            @(posedge clk);
            #1;
            `CHK(rde, 1'b0)
            `CHK(ale, 1'b0)
        end
        $display("test_idle done");
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_fetch = 1'b0;
        req_miss = 1'b0;
        req_addr = 32'h0;
        req_wdata = 32'h0;
        cfg_pin_in = 4'h3;
        wait_cycles = 8'h00;
        test_reset_cfg();
        test_reads();
        test_writes();
        test_idle();
        results();
    end
endmodule // test_bps_strobes
